// file: design/dtc_pkg.sv
// Constants, field layout and carrier types for the dual timer/counter.
// Assumes an APB master on sys_clk and pins synchronised inside the block.
// How it works
// - In timing operation a timer counts up once per machine cycle.
// - One machine cycle is six CPU clocks.
// - Timer 0 event mode counts falling edges on count pin zero.
// - Count pin sampled once per machine cycle; edge is high sample then low sample.
// - Incremented count appears in the machine cycle after edge detection.
// - Edge recognition spans two machine cycles, so max event rate is clock/12.
// - Source select bit in timer mode register picks timing or events for timer 0.
// - Two-bit mode field per timer selects modes 0 to 3.
// - Mode 0 is 13 bits: high byte plus low five bits of low byte.
// - Overflow flag sets when the count wraps from all ones to zero.
// - Timer 0 counts only when run bit set and qualify off or irq pin high.
// - Setting a run bit leaves the count bytes unchanged.
// - Mode 1 is mode 0 with the full sixteen bits.
// - Mode 2 counts the low byte only, as an 8-bit auto-reload counter.
// - Mode 2 overflow sets flag and copies high byte into low byte.
// - Timer 1 in mode 3 is halted, as if its run bit were clear.
// - Timer 0 mode 3: low byte is 8-bit counter using timer 0 controls.
// - Timer 0 mode 3: high byte times only, uses timer 1 run bit and flag.
// - With timer 0 in mode 3, timer 1 runs unless in its own mode 3.
// - Option toggles count pin zero output on each timer 0 overflow.
// - Port mode bit enables the toggle; pin is 1 before first overflow.
package dtc_pkg;
    // Timing and address width
    localparam int MC_CLOCKS = 6;
    localparam int ADDR_W = 8;
    // Register byte offsets
    localparam logic [7:0] OFF_TIMER_MODE = 8'h00;
    localparam logic [7:0] OFF_TIMER_CONTROL = 8'h04;
    localparam logic [7:0] OFF_LOW_ZERO = 8'h08;
    localparam logic [7:0] OFF_HIGH_ZERO = 8'h0c;
    localparam logic [7:0] OFF_LOW_ONE = 8'h10;
    localparam logic [7:0] OFF_HIGH_ONE = 8'h14;
    localparam logic [7:0] OFF_PORT_TWO_MODE = 8'h18;
    // Timer mode register fields, timer 1 field sits T1_SHIFT above timer 0
    localparam int MODE_FIELD_LOW = 0;
    localparam int MODE_FIELD_HIGH = 1;
    localparam int SRC_SEL = 2;
    localparam int QUALIFY = 3;
    localparam int T1_SHIFT = 4;
    // Timer control register fields
    localparam int RUN_BIT_TIMER_ZERO = 4;
    localparam int OVERFLOW_FLAG_TIMER_ZERO = 5;
    localparam int RUN_BIT_TIMER_ONE = 6;
    localparam int OVERFLOW_FLAG_TIMER_ONE = 7;
    localparam logic [7:0] CONTROL_MASK = 8'hf0;
    // Port two mode register field
    localparam int OVERFLOW_TOGGLE_ENABLE = 0;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Modes
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    typedef struct packed {
        logic ovf;
        logic [7:0] lo;
        logic [7:0] hi;
    } dtc_cnt_t;

    typedef struct packed {
        logic fall;
        logic irq;
    } dtc_pin_evt_t;
endpackage

// file: design/dtc_pin_sampler.sv
// Pin synchroniser and once-per-machine-cycle falling edge detector.
// Assumes mc_tick is a one-clock pulse from the same sys_clk domain.
`timescale 1ns/10ps
module dtc_pin_sampler (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    // Machine cycle strobe
    input wire logic mc_tick,
    // Asynchronous pins
    input wire logic count_pin_zero_in,
    input wire logic external_irq_pin_zero,
    // Synchronised results
    output dtc_pkg::dtc_pin_evt_t evt
);
    typedef struct packed {
        logic cnt_s1;
        logic cnt_s2;
        logic irq_s1;
        logic irq_s2;
        logic samp;
        logic fall;
    } dtc_smp_t;

    dtc_smp_t s;
    dtc_smp_t next_s;

    always_comb begin
        next_s = s;
        next_s.cnt_s1 = count_pin_zero_in;
        next_s.cnt_s2 = s.cnt_s1;
        next_s.irq_s1 = external_irq_pin_zero;
        next_s.irq_s2 = s.irq_s1;
        if (mc_tick) begin
            // One sample per machine cycle; fall stays up for the whole next cycle
            next_s.samp = s.cnt_s2;
            next_s.fall = s.samp && !s.cnt_s2;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign evt.fall = s.fall;
    assign evt.irq = s.irq_s2;

    property p_edge_seen;
        @(posedge sys_clk) disable iff (!nrst || !ce)
        (mc_tick && s.samp && !s.cnt_s2) |=> s.fall;
    endproperty
    a_edge_seen: assert property (p_edge_seen) else $error("falling sample pair not flagged");
endmodule

// file: design/dtc_dual_timer.sv
// Dual timer/counter with APB register access and count pin toggle output.
// Assumes APB master on sys_clk; count and irq pins are asynchronous.
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/10ps
module dtc_dual_timer #(
    parameter int MC_CLOCKS = dtc_pkg::MC_CLOCKS,
    parameter int ADDR_W = dtc_pkg::ADDR_W
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    // APB slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic count_pin_zero_in,
    output logic count_pin_zero_out,
    output logic count_pin_zero_oe,
    input wire logic external_irq_pin_zero,
    // Status
    output logic overflow_flag_timer_zero,
    output logic overflow_flag_timer_one,
    output logic timer_one_overflow
);
    if (MC_CLOCKS < 2 || MC_CLOCKS > 8) begin : g_bad_mc
        $error("MC_CLOCKS must be 2 to 8");
    end
    if (ADDR_W < 5) begin : g_bad_addr
        $error("ADDR_W must be at least 5");
    end

    typedef struct packed {
        logic [2:0] presc;
        logic [7:0] timer_mode_reg;
        logic [7:0] timer_control_reg;
        logic [7:0] low_count_byte_zero;
        logic [7:0] high_count_byte_zero;
        logic [7:0] low_count_byte_one;
        logic [7:0] high_count_byte_one;
        logic overflow_toggle_enable;
        logic pin_out;
        logic t1_ovf;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } dtc_state_t;

    dtc_state_t s;
    dtc_state_t next_s;
    dtc_pkg::dtc_pin_evt_t evt;

    logic tick;
    logic access;
    logic commit;
    logic [7:0] addr8;
    logic [1:0] mode0;
    logic [1:0] mode1;
    logic run0;
    logic run1;
    logic gate0;
    logic inc0;
    logic t1_on;
    logic ovf0;
    logic ovf1;
    logic hit;
    logic [7:0] rbyte;
    dtc_pkg::dtc_cnt_t step0;
    dtc_pkg::dtc_cnt_t step1;

    // Shared step for modes 0 to 2; mode 3 handled by the caller
    function automatic dtc_pkg::dtc_cnt_t step(input logic [1:0] md, input logic [7:0] lo,
                                               input logic [7:0] hi, input logic en);
        dtc_pkg::dtc_cnt_t r;
        r.ovf = 1'b0;
        r.lo = lo;
        r.hi = hi;
        if (en) begin
            case (md)
                dtc_pkg::MODE_13BIT: begin
                    // Top three low-byte bits are left alone and carry nothing
                    r.lo = {lo[7:5], lo[4:0] + 5'h01};
                    if (lo[4:0] == 5'h1f) begin
                        r.hi = hi + 8'h01;
                    end
                    r.ovf = (lo[4:0] == 5'h1f) && (hi == 8'hff);
                end
                dtc_pkg::MODE_16BIT: begin
                    {r.hi, r.lo} = {hi, lo} + 16'h0001;
                    r.ovf = ({hi, lo} == 16'hffff);
                end
                dtc_pkg::MODE_RELOAD: begin
                    if (lo == 8'hff) begin
                        r.lo = hi;
                        r.ovf = 1'b1;
                    end else begin
                        r.lo = lo + 8'h01;
                    end
                end
                default: begin
                    r.ovf = 1'b0;
                end
            endcase
        end
        return r;
    endfunction

    dtc_pin_sampler u_sampler (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .ce(ce),
        .mc_tick(tick),
        .count_pin_zero_in(count_pin_zero_in),
        .external_irq_pin_zero(external_irq_pin_zero),
        .evt(evt)
    );

    always_comb begin
        tick = (s.presc == 3'(MC_CLOCKS - 1));
        access = psel && penable;
        commit = access && s.pready;
        addr8 = 8'(paddr);
        mode0 = {s.timer_mode_reg[dtc_pkg::MODE_FIELD_HIGH], s.timer_mode_reg[dtc_pkg::MODE_FIELD_LOW]};
        mode1 = {s.timer_mode_reg[dtc_pkg::T1_SHIFT + dtc_pkg::MODE_FIELD_HIGH],
                 s.timer_mode_reg[dtc_pkg::T1_SHIFT + dtc_pkg::MODE_FIELD_LOW]};
        run0 = s.timer_control_reg[dtc_pkg::RUN_BIT_TIMER_ZERO];
        run1 = s.timer_control_reg[dtc_pkg::RUN_BIT_TIMER_ONE];
        gate0 = run0 && (!s.timer_mode_reg[dtc_pkg::QUALIFY] || evt.irq);
        // Edge found at one tick is counted at the next, so the new value shows a cycle later
        inc0 = gate0 && tick && (s.timer_mode_reg[dtc_pkg::SRC_SEL] ? evt.fall : 1'b1);
        // Timer 1 has no pin; in split mode it is started and stopped by its own mode
        t1_on = (mode1 != dtc_pkg::MODE_SPLIT) && ((mode0 == dtc_pkg::MODE_SPLIT) || run1);
        step1 = step(mode1, s.low_count_byte_one, s.high_count_byte_one, t1_on && tick);
        step0 = step(mode0, s.low_count_byte_zero, s.high_count_byte_zero, inc0);
        ovf1 = step1.ovf;
        if (mode0 == dtc_pkg::MODE_SPLIT) begin
            step0.lo = s.low_count_byte_zero + 8'h01;
            step0.ovf = inc0 && (s.low_count_byte_zero == 8'hff);
            if (!inc0) begin
                step0.lo = s.low_count_byte_zero;
            end
            step0.hi = s.high_count_byte_zero;
            ovf1 = 1'b0;
            if (tick && run1) begin
                step0.hi = s.high_count_byte_zero + 8'h01;
                ovf1 = (s.high_count_byte_zero == 8'hff);
            end
        end
        ovf0 = step0.ovf;

        // Register read mux
        hit = 1'b1;
        if (addr8 == dtc_pkg::OFF_TIMER_MODE) begin
            rbyte = s.timer_mode_reg;
        end else if (addr8 == dtc_pkg::OFF_TIMER_CONTROL) begin
            rbyte = s.timer_control_reg & dtc_pkg::CONTROL_MASK;
        end else if (addr8 == dtc_pkg::OFF_LOW_ZERO) begin
            rbyte = s.low_count_byte_zero;
        end else if (addr8 == dtc_pkg::OFF_HIGH_ZERO) begin
            rbyte = s.high_count_byte_zero;
        end else if (addr8 == dtc_pkg::OFF_LOW_ONE) begin
            rbyte = s.low_count_byte_one;
        end else if (addr8 == dtc_pkg::OFF_HIGH_ONE) begin
            rbyte = s.high_count_byte_one;
        end else if (addr8 == dtc_pkg::OFF_PORT_TWO_MODE) begin
            rbyte = {7'h00, s.overflow_toggle_enable};
        end else begin
            rbyte = 8'h00;
            hit = 1'b0;
        end
        if (paddr[1:0] != 2'h0 || ADDR_W > 8 && (paddr >> 8) != '0) begin
            hit = 1'b0;
            rbyte = 8'h00;
        end

        next_s = s;
        next_s.presc = tick ? 3'h0 : s.presc + 3'h1;
        next_s.low_count_byte_zero = step0.lo;
        next_s.high_count_byte_zero = step0.hi;
        next_s.low_count_byte_one = step1.lo;
        next_s.high_count_byte_one = step1.hi;
        next_s.t1_ovf = step1.ovf;

        // APB: one wait state, answer registered
        next_s.pready = access && !s.pready;
        if (access && !s.pready) begin
            next_s.prdata = {24'h00_0000, pwrite ? 8'h00 : rbyte};
            next_s.pslverr = !hit;
        end else begin
            next_s.pslverr = 1'b0;
        end

        // Software write beats the count step; a write to run bits leaves counts alone
        if (commit && pwrite && hit) begin
            if (addr8 == dtc_pkg::OFF_TIMER_MODE) begin
                next_s.timer_mode_reg = pwdata[7:0];
            end else if (addr8 == dtc_pkg::OFF_TIMER_CONTROL) begin
                next_s.timer_control_reg = pwdata[7:0] & dtc_pkg::CONTROL_MASK;
            end else if (addr8 == dtc_pkg::OFF_LOW_ZERO) begin
                next_s.low_count_byte_zero = pwdata[7:0];
            end else if (addr8 == dtc_pkg::OFF_HIGH_ZERO) begin
                next_s.high_count_byte_zero = pwdata[7:0];
            end else if (addr8 == dtc_pkg::OFF_LOW_ONE) begin
                next_s.low_count_byte_one = pwdata[7:0];
            end else if (addr8 == dtc_pkg::OFF_HIGH_ONE) begin
                next_s.high_count_byte_one = pwdata[7:0];
            end else if (addr8 == dtc_pkg::OFF_PORT_TWO_MODE) begin
                next_s.overflow_toggle_enable = pwdata[dtc_pkg::OVERFLOW_TOGGLE_ENABLE];
            end
        end

        // Set wins over a software clear in the same cycle
        if (ovf0) begin
            next_s.timer_control_reg[dtc_pkg::OVERFLOW_FLAG_TIMER_ZERO] = 1'b1;
        end
        if (ovf1) begin
            next_s.timer_control_reg[dtc_pkg::OVERFLOW_FLAG_TIMER_ONE] = 1'b1;
        end

        // Pin idles high so it reads 1 before the first overflow after enabling
        if (!s.overflow_toggle_enable || !next_s.overflow_toggle_enable) begin
            next_s.pin_out = 1'b1;
        end else if (ovf0) begin
            next_s.pin_out = !s.pin_out;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign count_pin_zero_out = s.pin_out;
    assign count_pin_zero_oe = s.overflow_toggle_enable;
    assign overflow_flag_timer_zero = s.timer_control_reg[dtc_pkg::OVERFLOW_FLAG_TIMER_ZERO];
    assign overflow_flag_timer_one = s.timer_control_reg[dtc_pkg::OVERFLOW_FLAG_TIMER_ONE];
    assign timer_one_overflow = s.t1_ovf;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst || !ce);

    sequence s_quiet5;
        !tick [*5];
    endsequence
    property p_mc_period;
        tick |=> s_quiet5 ##1 tick;
    endproperty
    a_mc_period: assert property (p_mc_period) else $error("machine cycle is not six clocks");

    property p_timer_inc;
        (tick && mode0 == dtc_pkg::MODE_16BIT && !s.timer_mode_reg[dtc_pkg::SRC_SEL] && gate0 && !commit)
        |=> {s.high_count_byte_zero, s.low_count_byte_zero} ==
            $past({s.high_count_byte_zero, s.low_count_byte_zero}) + 16'h0001;
    endproperty
    a_timer_inc: assert property (p_timer_inc) else $error("timer 0 missed a machine cycle");

    property p_event_inc;
        (tick && mode0 == dtc_pkg::MODE_16BIT && s.timer_mode_reg[dtc_pkg::SRC_SEL] && evt.fall && gate0 && !commit)
        |=> {s.high_count_byte_zero, s.low_count_byte_zero} ==
            $past({s.high_count_byte_zero, s.low_count_byte_zero}) + 16'h0001;
    endproperty
    a_event_inc: assert property (p_event_inc) else $error("event edge not counted");

    property p_gate_hold;
        (!gate0 && mode0 != dtc_pkg::MODE_SPLIT && !commit)
        |=> $stable(s.low_count_byte_zero) && $stable(s.high_count_byte_zero);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("timer 0 counted while gated off");

    property p_reload;
        (inc0 && mode0 == dtc_pkg::MODE_RELOAD && s.low_count_byte_zero == 8'hff && !commit)
        |=> s.low_count_byte_zero == $past(s.high_count_byte_zero) && overflow_flag_timer_zero;
    endproperty
    a_reload: assert property (p_reload) else $error("mode 2 reload failed");

    property p_t1_halt;
        (mode1 == dtc_pkg::MODE_SPLIT && !commit)
        |=> $stable(s.low_count_byte_one) && $stable(s.high_count_byte_one);
    endproperty
    a_t1_halt: assert property (p_t1_halt) else $error("timer 1 counted in mode 3");

    property p_split_high;
        (mode0 == dtc_pkg::MODE_SPLIT && tick && run1 && !commit)
        |=> s.high_count_byte_zero == $past(s.high_count_byte_zero) + 8'h01;
    endproperty
    a_split_high: assert property (p_split_high) else $error("split high byte did not count");

    property p_flag_set;
        ovf0 |=> overflow_flag_timer_zero;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("overflow flag not set");

    property p_toggle;
        (s.overflow_toggle_enable && next_s.overflow_toggle_enable && ovf0)
        |=> count_pin_zero_out != $past(count_pin_zero_out);
    endproperty
    a_toggle: assert property (p_toggle) else $error("pin did not toggle on overflow");

    property p_toggle_idle;
        (nrst && !s.overflow_toggle_enable) |=> count_pin_zero_out;
    endproperty
    a_toggle_idle: assert property (p_toggle_idle) else $error("pin not high before first overflow");

    sequence s_fall_waits;
        (!tick && evt.fall) [*5];
    endsequence
    sequence s_fall_counted;
        tick && evt.fall;
    endsequence
    // An edge seen at one tick is applied at the next one, never at the same one
    property p_ev_latency;
        $rose(evt.fall) |-> s_fall_waits ##1 s_fall_counted;
    endproperty
    a_ev_latency: assert property (p_ev_latency) else $error("late edge count");

    property p_ev_spacing;
        s_fall_counted |=> !evt.fall;
    endproperty
    a_ev_spacing: assert property (p_ev_spacing) else $error("two edges in adjacent cycles");

    property p_run_keeps_count;
        (commit && pwrite && addr8 == dtc_pkg::OFF_TIMER_CONTROL && !tick)
        |=> $stable(s.low_count_byte_zero) && $stable(s.high_count_byte_zero);
    endproperty
    a_run_keeps_count: assert property (p_run_keeps_count) else $error("run bit write changed count");

    property p_split_low_hold;
        (mode0 == dtc_pkg::MODE_SPLIT && !inc0 && !commit) |=> $stable(s.low_count_byte_zero);
    endproperty
    a_split_low_hold: assert property (p_split_low_hold) else $error("split low byte ran ungated");

    property p_t1_free;
        (mode0 == dtc_pkg::MODE_SPLIT && mode1 == dtc_pkg::MODE_16BIT && tick && !commit)
        |=> {s.high_count_byte_one, s.low_count_byte_one} ==
            $past({s.high_count_byte_one, s.low_count_byte_one}) + 16'h0001;
    endproperty
    a_t1_free: assert property (p_t1_free) else $error("timer 1 stopped outside its mode 3");

    property p_t1_tick_only;
        (!tick && !commit) |=> $stable(s.low_count_byte_one) && $stable(s.high_count_byte_one);
    endproperty
    a_t1_tick_only: assert property (p_t1_tick_only) else $error("timer 1 moved off a tick");
endmodule

// file: dv/dtc_pin_source.sv
// Far-side model: the source on count pin zero and on external irq pin zero.
// Assumes the bench calls its tasks; levels change just after a rising sys_clk edge.
`timescale 1ns/10ps
module dtc_pin_source (
    // Clock
    input wire logic sys_clk,
    // Pins toward the block
    output logic count_pin,
    output logic irq_pin
);
    // Pin idles high so that the first low level forms a falling edge
    initial begin
        count_pin = 1'b1;
        irq_pin = 1'b1;
    end

    // Low level held 9 clocks, high level 10: one machine cycle plus synchroniser margin
    task automatic falls(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            count_pin <= 1'b0;
            repeat (9) @(posedge sys_clk);
            count_pin <= 1'b1;
            repeat (9) @(posedge sys_clk);
        end
    endtask

    task automatic set_irq(input logic v);
        @(posedge sys_clk);
        irq_pin <= v;
    endtask
endmodule

// file: dv/dtc_dual_timer_tb_top.sv
// Self-checking bench for the dual timer/counter, driven over APB.
// Assumes the pin source model in dtc_pin_source and a 50 MHz sys_clk.
`timescale 1ns/10ps
module dtc_dual_timer_tb_top;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, pin_in, pin_out, pin_oe, irq_pin, ovf0, ovf1, t1_ovf;
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [31:0] rdata;
    logic err;
    int t_a, t_b;
    logic [7:0] lo_tab [3] = '{8'h1f, 8'hff, 8'hff};
    logic [7:0] hi_exp [3] = '{8'h00, 8'h00, 8'h80};

    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;

    dtc_dual_timer dtc_dual_timer_inst (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_pin_zero_in(pin_in), .count_pin_zero_out(pin_out), .count_pin_zero_oe(pin_oe),
        .external_irq_pin_zero(irq_pin), .overflow_flag_timer_zero(ovf0), .overflow_flag_timer_one(ovf1),
        .timer_one_overflow(t1_ovf));
    dtc_pin_source dtc_pin_source_inst (.sys_clk(sys_clk), .count_pin(pin_in), .irq_pin(irq_pin));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) num_errors++;
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(a, 1'b1, {24'h00_0000, d});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        apb(a, 1'b0, 32'h0000_0000);
        check(rdata, {24'h00_0000, exp});
        check({31'h0000_0000, err}, 32'h0000_0000);
    endtask

    // Waits a bounded number of clocks for a signal to read high
    task automatic wait_high(input int which, input int lim);
        int n;
        n = 0;
        while ((which == 0 ? ovf0 : which == 1 ? ovf1 : t1_ovf) !== 1'b1 && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
        check(n < lim, 1);
    endtask

    task automatic wait_toggle(output int t);
        logic p;
        int n;
        p = pin_out;
        n = 0;
        while (pin_out === p && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        t = cyc;
        check(n < 100, 1);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check(pin_out, 1);
        for (int i = 0; i < 7; i++) rd(8'(4 * i), 8'h00);
        apb(8'h1c, 1'b0, 32'h0000_0000);
        check(err, 1);
        $display("test reset done");
        // Each of modes 0 to 2 must reach overflow within 20 clocks of setting the run bit
        for (int m = 0; m < 3; m++) begin
            wr(dtc_pkg::OFF_TIMER_MODE, 8'(m));
            wr(dtc_pkg::OFF_HIGH_ZERO, m == 2 ? 8'h80 : 8'hff);
            wr(dtc_pkg::OFF_LOW_ZERO, lo_tab[m]);
            wr(dtc_pkg::OFF_TIMER_CONTROL, 8'h10);
            wait_high(0, 20);
            wr(dtc_pkg::OFF_TIMER_CONTROL, 8'h00);
            @(posedge sys_clk);
            check(ovf0, 0);
            rd(dtc_pkg::OFF_HIGH_ZERO, hi_exp[m]);
            if (m == 2) rd(dtc_pkg::OFF_LOW_ZERO, 8'h80);
        end
        $display("test modes done");
        wr(dtc_pkg::OFF_PORT_TWO_MODE, 8'h01);
        @(posedge sys_clk);
        check({pin_oe, pin_out}, 3);
        wr(dtc_pkg::OFF_TIMER_MODE, 8'h02);
        wr(dtc_pkg::OFF_HIGH_ZERO, 8'hfc);
        wr(dtc_pkg::OFF_LOW_ZERO, 8'hfc);
        wr(dtc_pkg::OFF_TIMER_CONTROL, 8'h10);
        wait_toggle(t_a);
        wait_toggle(t_b);
        check(t_b - t_a, 4 * dtc_pkg::MC_CLOCKS);
        wr(dtc_pkg::OFF_TIMER_CONTROL, 8'h00);
        wr(dtc_pkg::OFF_PORT_TWO_MODE, 8'h00);
        $display("test toggle done");
        wr(dtc_pkg::OFF_TIMER_MODE, 8'h05);
        wr(dtc_pkg::OFF_LOW_ZERO, 8'h00);
        wr(dtc_pkg::OFF_TIMER_CONTROL, 8'h10);
        dtc_pin_source_inst.falls(3);
        repeat (20) @(posedge sys_clk);
        rd(dtc_pkg::OFF_LOW_ZERO, 8'h03);
        wr(dtc_pkg::OFF_TIMER_MODE, 8'h0d);
        dtc_pin_source_inst.set_irq(1'b0);
        dtc_pin_source_inst.falls(2);
        repeat (20) @(posedge sys_clk);
        rd(dtc_pkg::OFF_LOW_ZERO, 8'h03);
        dtc_pin_source_inst.set_irq(1'b1);
        dtc_pin_source_inst.falls(2);
        repeat (20) @(posedge sys_clk);
        rd(dtc_pkg::OFF_LOW_ZERO, 8'h05);
        wr(dtc_pkg::OFF_TIMER_CONTROL, 8'h00);
        $display("test events done");
        wr(dtc_pkg::OFF_TIMER_MODE, 8'h30);
        wr(dtc_pkg::OFF_LOW_ONE, 8'h00);
        wr(dtc_pkg::OFF_TIMER_CONTROL, 8'h40);
        repeat (40) @(posedge sys_clk);
        rd(dtc_pkg::OFF_LOW_ONE, 8'h00);
        wr(dtc_pkg::OFF_TIMER_MODE, 8'h13);
        wr(dtc_pkg::OFF_HIGH_ZERO, 8'hfe);
        wr(dtc_pkg::OFF_HIGH_ONE, 8'hff);
        wr(dtc_pkg::OFF_LOW_ONE, 8'hff);
        wait_high(1, 30);
        check(ovf0, 0);
        wr(dtc_pkg::OFF_TIMER_CONTROL, 8'h00);
        // The first overflow left the high byte at zero, so reload it before the next one
        wr(dtc_pkg::OFF_HIGH_ONE, 8'hff);
        wr(dtc_pkg::OFF_LOW_ONE, 8'hff);
        wait_high(2, 30);
        check(ovf1, 0);
        wr(dtc_pkg::OFF_TIMER_MODE, 8'h33);
        wr(dtc_pkg::OFF_LOW_ONE, 8'h7f);
        repeat (30) @(posedge sys_clk);
        rd(dtc_pkg::OFF_LOW_ONE, 8'h7f);
        $display("test split done");
        // With the clock enable low a timer one tick from overflow must not move
        wr(dtc_pkg::OFF_TIMER_MODE, 8'h01);
        wr(dtc_pkg::OFF_HIGH_ZERO, 8'hff);
        wr(dtc_pkg::OFF_LOW_ZERO, 8'hff);
        wr(dtc_pkg::OFF_TIMER_CONTROL, 8'h10);
        ce <= 1'b0;
        repeat (30) @(posedge sys_clk);
        check(ovf0, 0);
        ce <= 1'b1;
        wait_high(0, 20);
        wr(dtc_pkg::OFF_TIMER_CONTROL, 8'h00);
        $display("test enable done");
        print_verdict();
    end
endmodule
